// ---- rtl/sound_ctl_pkg.sv ----
// Constants, message layout and state types for the playback and tone controller.
// Assumes a 100 MHz mclk and messages already parsed from the host link.
// Notes on behaviour
// - Codes 01 start, 02 stop, 03 stop-after-phrase
// - Codes 07 mute, 08 mute-after-phrase, 09 unmute
// - Start plays phrase for repeats, then idles
// - Repeat FF endless, FE 254, 00/01 once
// - Start while playing restarts new phrase
// - Stop now ends at once with fade-out
// - Stop-after-phrase ends when current phrase finishes
// - Stop ignores phrase and repeat fields
// - Dual start launches both channels together
// - Dual stop now ends both with fade-out
// - Dual stop-after-phrase ends each at phrase end
// - Status high while any playback runs
// - Mute now fades out, playback continues
// - Mute-after-phrase silences at phrase end
// - Data ending while muted idles, clears mute
// - Unmute fades in, playback continues
// - Tone control 01 single tone until 02
// - Square wave Hz equals code 001F..3E80
// - Pattern cycles tones 0..3 with gaps
// - Zero tone time ends pattern there
// - Times count in 10 ms units
// - Pattern repeat FF endless, 00/01 once
// - Amplifier output on 01, off 00
package sound_ctl_pkg;

  // ***********************
  // Timing
  // ***********************
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TONE_UNIT_NS = 10_000_000;
  localparam int TONE_UNIT_CYCLES = TONE_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [25:0] HALF_CLK_HZ = 26'(CLK_HZ / 2);

  // ***********************
  // Codes
  // ***********************
  localparam logic [7:0] CMD_START = 8'h01;
  localparam logic [7:0] CMD_STOP_NOW = 8'h02;
  localparam logic [7:0] CMD_STOP_PHRASE = 8'h03;
  localparam logic [7:0] CMD_MUTE_NOW = 8'h07;
  localparam logic [7:0] CMD_MUTE_PHRASE = 8'h08;
  localparam logic [7:0] CMD_UNMUTE = 8'h09;
  localparam logic [7:0] REP_ENDLESS = 8'hFF;
  localparam logic [7:0] REP_ONCE = 8'h01;
  localparam logic [7:0] TONE_PATTERN = 8'h00;
  localparam logic [7:0] TONE_SINGLE = 8'h01;
  localparam logic [7:0] TONE_STOP = 8'h02;
  localparam logic [7:0] AMP_ON = 8'h01;
  localparam logic [7:0] AMP_OFF = 8'h00;
  localparam logic [15:0] PITCH_MIN = 16'h001F;
  localparam logic [15:0] PITCH_MAX = 16'h3E80;
  localparam int MSG_FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    MSG_OUT_EN = 2'h0,
    MSG_CHANNEL = 2'h1,
    MSG_DUAL = 2'h2,
    MSG_TONE = 2'h3
  } msg_kind_e;

  typedef enum logic [1:0] {
    TONE_IDLE = 2'h0,
    TONE_ON = 2'h1,
    TONE_GAP = 2'h2
  } tone_state_e;

  typedef struct packed {
    logic [3:0][15:0] tone_pitch_hz;
    logic [3:0][7:0] tone_on_time;
    logic [3:0][7:0] tone_gap_time;
  } tone_cfg_s;

  // Channel message uses slot 0 of phrase and repeat fields
  typedef struct packed {
    msg_kind_e kind;
    logic chan;
    logic [7:0] cmd;
    logic [1:0][15:0] phrase_index;
    logic [1:0][7:0] play_repeat_count;
    tone_cfg_s tone;
    logic [7:0] tone_repeat;
  } msg_s;

  typedef struct packed {
    logic active;
    logic endless;
    logic stop_pend;
    logic mute;
    logic mute_pend;
    logic [7:0] rem;
    logic [15:0] phrase;
  } chan_s;

  typedef struct packed {
    tone_state_e st;
    logic [1:0] idx;
    logic [7:0] cnt;
    logic [7:0] rem;
    logic endless;
    logic single;
  } tone_s;

  localparam chan_s CHAN_RESET = '0;
  localparam tone_s TONE_RESET = '{st: TONE_IDLE, default: '0};

endpackage

// ---- rtl/msg_fifo.sv ----
// Synchronous FIFO holding parsed host messages.
// Assumes one clock; reader may stall, writer sees honest ready.
`timescale 1ns/1ps
module msg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
  logic push, pop;

  assign in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_reg != rd_reg;
  assign out_data = mem[rd_reg[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end
endmodule

// ---- rtl/sound_playback_tone_control.sv ----
// Command interpreter for two playback channels and a square-wave tone generator.
// Assumes the decode datapath reports phrase and sentence ends as one-cycle pulses.
`timescale 1ns/1ps
module sound_playback_tone_control #(
  parameter int TONE_TICK_CYCLES = sound_ctl_pkg::TONE_UNIT_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic msg_valid,
  input wire sound_ctl_pkg::msg_s msg,
  output logic msg_ready,
  input wire logic engine_ready,
  input wire logic [1:0] phrase_end,
  input wire logic [1:0] sentence_end,
  output logic [1:0] play_start,
  output logic [1:0][15:0] play_phrase,
  output logic [1:0] fade_out,
  output logic [1:0] fade_in,
  output logic [1:0] ch_muted,
  output logic [1:0] ch_active,
  output logic status_out,
  output logic amp_enable_out,
  output logic sound_pins_oe,
  output logic tone_wave,
  output logic tone_active,
  output logic cmd_error
);

  // ***********************
  // Message queue
  // ***********************
  sound_ctl_pkg::msg_s m;
  logic m_valid;
  logic take;

  msg_fifo #(
    .WIDTH($bits(sound_ctl_pkg::msg_s)),
    .DEPTH(sound_ctl_pkg::MSG_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_valid(msg_valid),
    .in_ready(msg_ready),
    .in_data(msg),
    .out_valid(m_valid),
    .out_ready(engine_ready),
    .out_data(m)
  );

  // Stalled datapath holds messages in the queue
  assign take = m_valid && engine_ready;

  function automatic logic pitch_ok(input logic [15:0] f);
    pitch_ok = (f >= sound_ctl_pkg::PITCH_MIN) && (f <= sound_ctl_pkg::PITCH_MAX);
  endfunction

  function automatic logic play_cmd_ok(input logic [7:0] c);
    play_cmd_ok = c inside {sound_ctl_pkg::CMD_START, sound_ctl_pkg::CMD_STOP_NOW,
      sound_ctl_pkg::CMD_STOP_PHRASE, sound_ctl_pkg::CMD_MUTE_NOW,
      sound_ctl_pkg::CMD_MUTE_PHRASE, sound_ctl_pkg::CMD_UNMUTE};
  endfunction

  // ***********************
  // Playback channels
  // ***********************
  sound_ctl_pkg::chan_s [1:0] ch_reg, ch_next;
  logic [1:0] start_next, fo_next, fi_next;
  logic [1:0] start_reg, fo_reg, fi_reg;
  logic err_next, err_reg;
  logic amp_reg, amp_next;
  logic play_ok, play_hit;
  logic [1:0] ch_hit;

  always_comb begin
    play_ok = play_cmd_ok(m.cmd);
    play_hit = take && (m.kind == sound_ctl_pkg::MSG_CHANNEL ||
      m.kind == sound_ctl_pkg::MSG_DUAL);
    for (int i = 0; i < 2; i++) begin
      ch_hit[i] = play_hit && play_ok &&
        (m.kind == sound_ctl_pkg::MSG_DUAL || m.chan == 1'(i));
    end
  end

  always_comb begin
    logic [7:0] rep;
    logic [15:0] ph;
    rep = '0;
    ph = '0;
    ch_next = ch_reg;
    start_next = '0;
    fo_next = '0;
    fi_next = '0;
    for (int i = 0; i < 2; i++) begin
      // Datapath events first; a command in the same cycle overrides them
      if (ch_reg[i].active && phrase_end[i]) begin
        if (ch_reg[i].stop_pend) begin
          ch_next[i] = sound_ctl_pkg::CHAN_RESET;
        end else if (ch_reg[i].mute_pend) begin
          ch_next[i].mute = 1'b1;
          ch_next[i].mute_pend = 1'b0;
          fo_next[i] = 1'b1;
        end
      end
      if (ch_reg[i].active && sentence_end[i] && ch_next[i].active) begin
        if (ch_reg[i].endless || ch_reg[i].rem > sound_ctl_pkg::REP_ONCE) begin
          if (!ch_reg[i].endless) begin
            ch_next[i].rem = ch_reg[i].rem - 1'b1;
          end
          start_next[i] = 1'b1;
        end else begin
          // Clears mute too, so the next playback is audible
          ch_next[i] = sound_ctl_pkg::CHAN_RESET;
        end
      end
      if (ch_hit[i]) begin
        ph = (m.kind == sound_ctl_pkg::MSG_DUAL) ? m.phrase_index[i] : m.phrase_index[0];
        rep = (m.kind == sound_ctl_pkg::MSG_DUAL) ? m.play_repeat_count[i] :
          m.play_repeat_count[0];
        case (m.cmd)
          sound_ctl_pkg::CMD_START: begin
            // Restart from the top even if already playing
            ch_next[i] = sound_ctl_pkg::CHAN_RESET;
            ch_next[i].active = 1'b1;
            ch_next[i].phrase = ph;
            ch_next[i].endless = rep == sound_ctl_pkg::REP_ENDLESS;
            ch_next[i].rem = (rep <= sound_ctl_pkg::REP_ONCE) ? sound_ctl_pkg::REP_ONCE : rep;
            start_next[i] = 1'b1;
          end
          sound_ctl_pkg::CMD_STOP_NOW: begin
            // Phrase and repeat fields are not looked at
            fo_next[i] = ch_reg[i].active;
            start_next[i] = 1'b0;
            ch_next[i] = sound_ctl_pkg::CHAN_RESET;
          end
          sound_ctl_pkg::CMD_STOP_PHRASE: begin
            ch_next[i].stop_pend = ch_next[i].active;
          end
          sound_ctl_pkg::CMD_MUTE_NOW: begin
            if (ch_next[i].active) begin
              ch_next[i].mute = 1'b1;
              ch_next[i].mute_pend = 1'b0;
              fo_next[i] = !ch_reg[i].mute;
            end
          end
          sound_ctl_pkg::CMD_MUTE_PHRASE: begin
            ch_next[i].mute_pend = ch_next[i].active && !ch_next[i].mute;
          end
          sound_ctl_pkg::CMD_UNMUTE: begin
            fi_next[i] = ch_next[i].mute;
            ch_next[i].mute = 1'b0;
            ch_next[i].mute_pend = 1'b0;
          end
          default: begin
            ch_next[i] = ch_next[i];
          end
        endcase
      end
    end
  end

  // ***********************
  // Tone generator
  // ***********************
  sound_ctl_pkg::tone_s tone_reg, tone_next;
  sound_ctl_pkg::tone_cfg_s cfg_reg, cfg_next;
  logic [19:0] tick_reg, tick_next;
  logic [25:0] acc_reg, acc_next;
  logic wave_reg, wave_next;
  logic tick, tone_hit, tone_ok, cfg_live;

  // Next tone entry, or wrap and count one pass
  function automatic sound_ctl_pkg::tone_s advance(input sound_ctl_pkg::tone_s t,
      input sound_ctl_pkg::tone_cfg_s c);
    sound_ctl_pkg::tone_s n;
    n = t;
    if (t.idx != 2'h3 && c.tone_on_time[t.idx + 2'h1] != 8'h00) begin
      n.idx = t.idx + 2'h1;
      n.st = sound_ctl_pkg::TONE_ON;
      n.cnt = c.tone_on_time[n.idx];
    end else if (t.endless || t.rem > sound_ctl_pkg::REP_ONCE) begin
      // Zero time ends the pass; later entries never play
      n.rem = t.endless ? t.rem : t.rem - 1'b1;
      n.idx = 2'h0;
      n.st = sound_ctl_pkg::TONE_ON;
      n.cnt = c.tone_on_time[0];
    end else begin
      n = sound_ctl_pkg::TONE_RESET;
    end
    advance = n;
  endfunction

  assign tick = tick_reg == 20'(TONE_TICK_CYCLES - 1);

  always_comb begin
    tone_hit = take && m.kind == sound_ctl_pkg::MSG_TONE;
    tone_ok = 1'b0;
    cfg_live = 1'b1;
    case (m.cmd)
      sound_ctl_pkg::TONE_SINGLE: tone_ok = pitch_ok(m.tone.tone_pitch_hz[0]);
      sound_ctl_pkg::TONE_STOP: tone_ok = 1'b1;
      sound_ctl_pkg::TONE_PATTERN: begin
        tone_ok = m.tone.tone_on_time[0] != 8'h00;
        for (int i = 0; i < 4; i++) begin
          cfg_live = cfg_live && m.tone.tone_on_time[i] != 8'h00;
          if (cfg_live && !pitch_ok(m.tone.tone_pitch_hz[i])) begin
            tone_ok = 1'b0;
          end
        end
      end
      default: tone_ok = 1'b0;
    endcase
  end

  always_comb begin
    tone_next = tone_reg;
    cfg_next = cfg_reg;
    tick_next = tick ? '0 : tick_reg + 20'h1;
    if (tick && !tone_reg.single) begin
      case (tone_reg.st)
        sound_ctl_pkg::TONE_ON: begin
          if (tone_reg.cnt <= 8'h01) begin
            if (cfg_reg.tone_gap_time[tone_reg.idx] != 8'h00) begin
              tone_next.st = sound_ctl_pkg::TONE_GAP;
              tone_next.cnt = cfg_reg.tone_gap_time[tone_reg.idx];
            end else begin
              tone_next = advance(tone_reg, cfg_reg);
            end
          end else begin
            tone_next.cnt = tone_reg.cnt - 8'h01;
          end
        end
        sound_ctl_pkg::TONE_GAP: begin
          if (tone_reg.cnt <= 8'h01) begin
            tone_next = advance(tone_reg, cfg_reg);
          end else begin
            tone_next.cnt = tone_reg.cnt - 8'h01;
          end
        end
        default: tone_next = tone_reg;
      endcase
    end
    if (tone_hit && tone_ok) begin
      tick_next = '0;
      tone_next = sound_ctl_pkg::TONE_RESET;
      if (m.cmd != sound_ctl_pkg::TONE_STOP) begin
        cfg_next = m.tone;
        tone_next.st = sound_ctl_pkg::TONE_ON;
        tone_next.cnt = m.tone.tone_on_time[0];
        tone_next.single = m.cmd == sound_ctl_pkg::TONE_SINGLE;
        tone_next.endless = m.tone_repeat == sound_ctl_pkg::REP_ENDLESS;
        tone_next.rem = (m.tone_repeat <= sound_ctl_pkg::REP_ONCE) ?
          sound_ctl_pkg::REP_ONCE : m.tone_repeat;
      end
    end
  end

  // Phase accumulator gives exact frequency without a divider
  always_comb begin
    logic [25:0] sum;
    sum = acc_reg + 26'(cfg_reg.tone_pitch_hz[tone_reg.idx]);
    acc_next = sum;
    wave_next = wave_reg;
    if (tone_reg.st != sound_ctl_pkg::TONE_ON || tone_next.st != tone_reg.st ||
        tone_next.idx != tone_reg.idx) begin
      acc_next = '0;
      wave_next = 1'b0;
    end else if (sum >= sound_ctl_pkg::HALF_CLK_HZ) begin
      acc_next = sum - sound_ctl_pkg::HALF_CLK_HZ;
      wave_next = !wave_reg;
    end
  end

  // ***********************
  // Output enable and errors
  // ***********************
  always_comb begin
    amp_next = amp_reg;
    err_next = 1'b0;
    if (take && m.kind == sound_ctl_pkg::MSG_OUT_EN) begin
      if (m.cmd == sound_ctl_pkg::AMP_ON || m.cmd == sound_ctl_pkg::AMP_OFF) begin
        amp_next = m.cmd == sound_ctl_pkg::AMP_ON;
      end else begin
        err_next = 1'b1;
      end
    end
    if ((play_hit && !play_ok) || (tone_hit && !tone_ok)) begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ch_reg <= '0;
      start_reg <= '0;
      fo_reg <= '0;
      fi_reg <= '0;
      err_reg <= 1'b0;
      amp_reg <= 1'b0;
      tone_reg <= sound_ctl_pkg::TONE_RESET;
      cfg_reg <= '0;
      tick_reg <= '0;
      acc_reg <= '0;
      wave_reg <= 1'b0;
    end else begin
      ch_reg <= ch_next;
      start_reg <= start_next;
      fo_reg <= fo_next;
      fi_reg <= fi_next;
      err_reg <= err_next;
      amp_reg <= amp_next;
      tone_reg <= tone_next;
      cfg_reg <= cfg_next;
      tick_reg <= tick_next;
      acc_reg <= acc_next;
      wave_reg <= wave_next;
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ch_active[i] = ch_reg[i].active;
      ch_muted[i] = ch_reg[i].mute;
      play_phrase[i] = ch_reg[i].phrase;
    end
  end

  assign play_start = start_reg;
  assign fade_out = fo_reg;
  assign fade_in = fi_reg;
  assign status_out = ch_reg[0].active || ch_reg[1].active;
  assign amp_enable_out = amp_reg;
  // Pins drive only once the host has switched them on
  assign sound_pins_oe = amp_reg;
  assign tone_wave = wave_reg && amp_reg;
  assign tone_active = tone_reg.st != sound_ctl_pkg::TONE_IDLE;
  assign cmd_error = err_reg;

  // ***********************
  // Checks
  // ***********************
  logic cmd0;
  assign cmd0 = ch_hit[0];

  sequence s_cmd0(logic [7:0] c);
    cmd0 && m.cmd == c;
  endsequence

  a_start_launch: assert property (@(posedge mclk) disable iff (reset)
    s_cmd0(sound_ctl_pkg::CMD_START) |=> play_start[0] && ch_active[0])
    else $error("start did not launch channel 0");
  a_stop_now: assert property (@(posedge mclk) disable iff (reset)
    s_cmd0(sound_ctl_pkg::CMD_STOP_NOW) and ch_active[0] |=> !ch_active[0] && fade_out[0])
    else $error("stop now did not end channel 0 with fade");
  a_mute_now: assert property (@(posedge mclk) disable iff (reset)
    s_cmd0(sound_ctl_pkg::CMD_MUTE_NOW) and ch_active[0] |=> ch_muted[0] && ch_active[0])
    else $error("mute now did not mute while playing");
  a_unmute_fade: assert property (@(posedge mclk) disable iff (reset)
    s_cmd0(sound_ctl_pkg::CMD_UNMUTE) and ch_muted[0] |=> !ch_muted[0] && fade_in[0])
    else $error("unmute missed fade-in");
  a_end_clears: assert property (@(posedge mclk) disable iff (reset)
    ch_reg[0].active && sentence_end[0] && !ch_reg[0].endless &&
    ch_reg[0].rem == 8'h01 && !cmd0 |=> !ch_active[0] && !ch_muted[0])
    else $error("last sentence end did not idle and unmute");
  a_status_level: assert property (@(posedge mclk) disable iff (reset)
    play_start[0] |-> status_out)
    else $error("status low while channel 0 plays");
  a_bad_code: assert property (@(posedge mclk) disable iff (reset)
    play_hit && !play_ok |=> cmd_error && $stable(ch_reg))
    else $error("bad code not flagged or state moved");
  a_amp_follow: assert property (@(posedge mclk) disable iff (reset)
    take && m.kind == sound_ctl_pkg::MSG_OUT_EN && m.cmd == sound_ctl_pkg::AMP_ON
    |=> amp_enable_out && sound_pins_oe)
    else $error("amplifier did not switch on");
  a_single_hold: assert property (@(posedge mclk) disable iff (reset)
    tone_active && tone_reg.single && !tone_hit |=> tone_active)
    else $error("single tone ended by itself");
  a_tone_stop: assert property (@(posedge mclk) disable iff (reset)
    tone_hit && m.cmd == sound_ctl_pkg::TONE_STOP |=> !tone_active ##1 !tone_wave)
    else $error("tone stop ignored");
endmodule

// ---- tb/engine_model.sv ----
// Playback engine stand-in: phrase and sentence end pulses per channel.
// Assumes play_start and ch_active come from the controller's registers.
`timescale 1ns/1ps
module engine_model #(
  parameter int PH = 10
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [1:0] play_start,
  input wire logic [1:0] ch_active,
  output logic [1:0] phrase_end,
  output logic [1:0] sentence_end
);
  int cnt [2];
  // Three phrases to a sentence; a restart rewinds the count
  always @(posedge mclk) begin
    for (int c = 0; c < 2; c++) begin
      phrase_end[c] <= 1'b0;
      sentence_end[c] <= 1'b0;
      if (reset || play_start[c] || !ch_active[c]) begin
        cnt[c] <= 0;
      end else begin
        cnt[c] <= (cnt[c] == 3 * PH - 1) ? 0 : cnt[c] + 1;
        phrase_end[c] <= (cnt[c] % PH) == PH - 1;
        sentence_end[c] <= cnt[c] == 3 * PH - 1;
      end
    end
  end
endmodule

// ---- tb/test_sound_playback_tone_control.sv ----
// Self-checking bench for the playback and tone controller.
// Assumes engine_model on the datapath side and a 20-cycle tone tick.
`timescale 1ns/1ps
module test_sound_playback_tone_control;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic msg_valid = 1'b0;
  logic engine_ready = 1'b1;
  sound_ctl_pkg::msg_s msg = '0;
  sound_ctl_pkg::msg_s m;
  logic msg_ready, status_out, amp_enable_out, sound_pins_oe, tone_wave, tone_active, cmd_error;
  logic [1:0] phrase_end, sentence_end, play_start, fade_out, fade_in, ch_muted, ch_active;
  logic [1:0] act_q, mu_q, pe_q, fell_pe, mu_pe;
  logic [1:0][15:0] play_phrase;
  int n_errors = 0;
  int n_checks = 0;
  int nst = 0, nfo = 0, nfi = 0, ner = 0;
  int s, n;
  logic [7:0] reps [4] = '{8'h00, 8'h01, 8'h02, 8'hFE};
  int plays [4] = '{1, 1, 2, 254};
  logic [7:0] bad [3] = '{8'h00, 8'h04, 8'h0A};
  logic [15:0] hz [4] = '{16'h001E, 16'h001F, 16'h3E80, 16'h3E81};

  always #5 mclk = ~mclk;

  sound_playback_tone_control #(.TONE_TICK_CYCLES(20)) DUT (.mclk(mclk), .reset(reset),
    .msg_valid(msg_valid), .msg(msg), .msg_ready(msg_ready), .engine_ready(engine_ready),
    .phrase_end(phrase_end), .sentence_end(sentence_end), .play_start(play_start),
    .play_phrase(play_phrase), .fade_out(fade_out), .fade_in(fade_in), .ch_muted(ch_muted),
    .ch_active(ch_active), .status_out(status_out), .amp_enable_out(amp_enable_out),
    .sound_pins_oe(sound_pins_oe), .tone_wave(tone_wave), .tone_active(tone_active),
    .cmd_error(cmd_error));

  engine_model #(.PH(10)) engine (.mclk(mclk), .reset(reset), .play_start(play_start),
    .ch_active(ch_active), .phrase_end(phrase_end), .sentence_end(sentence_end));

  // ***********************
  // Pulse counters
  // ***********************
  // Pulses last one cycle, so they are tallied here rather than sampled
  always @(posedge mclk) begin
    act_q <= ch_active;
    mu_q <= ch_muted;
    pe_q <= phrase_end;
    if (!reset) begin
      nst <= nst + play_start[0] + play_start[1];
      nfo <= nfo + fade_out[0] + fade_out[1];
      nfi <= nfi + fade_in[0] + fade_in[1];
      ner <= ner + cmd_error;
      for (int c = 0; c < 2; c++) begin
        if (act_q[c] && !ch_active[c]) fell_pe[c] <= pe_q[c];
        if (!mu_q[c] && ch_muted[c]) mu_pe[c] <= pe_q[c];
      end
    end
  end

  // ***********************
  // Tasks
  // ***********************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic send(input int w = 4);
    @(posedge mclk);
    msg <= m;
    msg_valid <= 1'b1;
    do @(posedge mclk); while (msg_ready !== 1'b1);
    msg_valid <= 1'b0;
    repeat (w) @(posedge mclk);
  endtask

  task automatic ctl(input sound_ctl_pkg::msg_kind_e k, input logic [7:0] cmd,
      input logic [15:0] p0 = 16'h0000, input logic [7:0] r0 = 8'h00,
      input logic [15:0] p1 = 16'h0000, input logic [7:0] r1 = 8'h00);
    m = '0;
    m.kind = k;
    m.cmd = cmd;
    m.phrase_index = {p1, p0};
    m.play_repeat_count = {r1, r0};
    send();
  endtask

  // Pattern: 2 ticks on, 1 gap, 1 on, then a zero entry; tone 3 must never play
  task automatic tone(input logic [7:0] ctl, input logic [15:0] f, input logic [7:0] rep);
    m = '0;
    m.kind = sound_ctl_pkg::MSG_TONE;
    m.cmd = ctl;
    m.tone.tone_pitch_hz = {4{f}};
    m.tone.tone_on_time = {8'h05, 8'h00, 8'h01, 8'h02};
    m.tone.tone_gap_time = {8'h01, 8'h01, 8'h00, 8'h01};
    m.tone_repeat = rep;
    send(1);
  endtask

  task automatic wait_idle(input logic [1:0] mask);
    for (int i = 0; i < 9000 && (ch_active & mask) !== 2'b00; i++) @(posedge mclk);
    // One more edge so the fall tallies land
    @(posedge mclk);
    chk("idle", 32'h0, 32'(ch_active & mask));
  endtask

  task automatic fin(input string t);
    $display("test %s done: checks %0d errors %0d", t, n_checks, n_errors);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #1_000_000;
    n_errors++;
    test_done();
  end

  // ***********************
  // Tests
  // ***********************
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk("ready", 32'h1, msg_ready);
    chk("status", 32'h0, status_out);
    ctl(sound_ctl_pkg::MSG_OUT_EN, sound_ctl_pkg::AMP_ON);
    chk("amp", 32'h1, amp_enable_out);
    chk("pins", 32'h1, sound_pins_oe);
    s = ner;
    ctl(sound_ctl_pkg::MSG_OUT_EN, 8'h05);
    chk("err", s + 1, ner);
    chk("amp", 32'h1, amp_enable_out);
    fin("output enable");
    foreach (reps[i]) begin
      s = nst;
      ctl(sound_ctl_pkg::MSG_CHANNEL, sound_ctl_pkg::CMD_START, 16'h1234, reps[i]);
      chk("phrase", 32'h1234, play_phrase[0]);
      chk("status", 32'h1, status_out);
      wait_idle(2'b01);
      chk("plays", s + plays[i], nst);
      chk("status", 32'h0, status_out);
    end
    fin("repeat counts");
    ctl(sound_ctl_pkg::MSG_CHANNEL, sound_ctl_pkg::CMD_START, 16'h00AA, 8'hFF);
    foreach (bad[i]) begin
      s = ner;
      ctl(sound_ctl_pkg::MSG_CHANNEL, bad[i], 16'h0777, 8'h01);
      chk("err", s + 1, ner);
      chk("phrase", 32'h00AA, play_phrase[0]);
      chk("active", 32'h1, ch_active[0]);
    end
    s = nst;
    ctl(sound_ctl_pkg::MSG_CHANNEL, sound_ctl_pkg::CMD_START, 16'h0BBB, 8'hFF);
    chk("phrase", 32'h0BBB, play_phrase[0]);
    chk("restart", s + 1, nst);
    fin("codes and restart");
    s = nfo;
    ctl(sound_ctl_pkg::MSG_CHANNEL, sound_ctl_pkg::CMD_MUTE_NOW);
    chk("muted", 32'h1, ch_muted[0]);
    chk("active", 32'h1, ch_active[0]);
    chk("fade out", s + 1, nfo);
    s = nfi;
    ctl(sound_ctl_pkg::MSG_CHANNEL, sound_ctl_pkg::CMD_UNMUTE);
    chk("muted", 32'h0, ch_muted[0]);
    chk("fade in", s + 1, nfi);
    ctl(sound_ctl_pkg::MSG_CHANNEL, sound_ctl_pkg::CMD_MUTE_PHRASE);
    repeat (12) @(posedge mclk);
    chk("muted", 32'h1, ch_muted[0]);
    chk("mute at end", 32'h1, mu_pe[0]);
    s = nfo;
    ctl(sound_ctl_pkg::MSG_CHANNEL, sound_ctl_pkg::CMD_STOP_NOW, 16'hFFFF, 8'h07);
    chk("active", 32'h0, ch_active[0]);
    chk("fade out", s + 1, nfo);
    ctl(sound_ctl_pkg::MSG_CHANNEL, sound_ctl_pkg::CMD_START, 16'h0042, 8'h01);
    chk("muted", 32'h0, ch_muted[0]);
    ctl(sound_ctl_pkg::MSG_CHANNEL, sound_ctl_pkg::CMD_MUTE_NOW);
    wait_idle(2'b01);
    chk("muted", 32'h0, ch_muted[0]);
    ctl(sound_ctl_pkg::MSG_CHANNEL, sound_ctl_pkg::CMD_START, 16'h0042, 8'hFF);
    ctl(sound_ctl_pkg::MSG_CHANNEL, sound_ctl_pkg::CMD_STOP_PHRASE, 16'h5555, 8'h33);
    wait_idle(2'b01);
    chk("end at phrase", 32'h1, fell_pe[0]);
    fin("mute and stop");
    m = '0;
    m.kind = sound_ctl_pkg::MSG_CHANNEL;
    m.chan = 1'b1;
    m.cmd = sound_ctl_pkg::CMD_START;
    m.phrase_index[0] = 16'h0033;
    send();
    chk("chan", 32'h2, ch_active);
    chk("phrases", 32'h00330000, play_phrase);
    wait_idle(2'b10);
    ctl(sound_ctl_pkg::MSG_DUAL, sound_ctl_pkg::CMD_START, 16'h0011, 8'h01, 16'h0022, 8'h02);
    chk("phrases", 32'h00220011, play_phrase);
    chk("active", 32'h3, ch_active);
    wait_idle(2'b11);
    chk("status", 32'h0, status_out);
    ctl(sound_ctl_pkg::MSG_DUAL, sound_ctl_pkg::CMD_START, 16'h0011, 8'hFF, 16'h0022, 8'hFF);
    s = nfo;
    ctl(sound_ctl_pkg::MSG_DUAL, sound_ctl_pkg::CMD_STOP_NOW);
    chk("active", 32'h0, ch_active);
    chk("fade out", s + 2, nfo);
    ctl(sound_ctl_pkg::MSG_DUAL, sound_ctl_pkg::CMD_START, 16'h0011, 8'hFF, 16'h0022, 8'hFF);
    ctl(sound_ctl_pkg::MSG_DUAL, sound_ctl_pkg::CMD_STOP_PHRASE);
    wait_idle(2'b11);
    chk("end at phrase", 32'h3, fell_pe);
    fin("dual channel");
    // Channels are idle here; tone commands are taken whether or not they play
    foreach (hz[i]) begin
      s = ner;
      tone(sound_ctl_pkg::TONE_SINGLE, hz[i], 8'h00);
      repeat (3) @(posedge mclk);
      chk("err", s + (i == 0 || i == 3), ner);
      chk("tone", (i == 1 || i == 2), tone_active);
      if (i == 2) begin
        n = 0;
        while (tone_wave !== 1'b0) @(posedge mclk);
        while (tone_wave !== 1'b1) @(posedge mclk);
        while (tone_wave === 1'b1) begin
          @(posedge mclk);
          n++;
        end
        chk("half period", 32'h1, n >= 3124 && n <= 3126);
      end
      tone(sound_ctl_pkg::TONE_STOP, 16'h0000, 8'h00);
      repeat (3) @(posedge mclk);
      chk("tone", 32'h0, tone_active);
    end
    fin("single tone");
    foreach (plays[i]) begin
      if (i < 3) begin
        tone(sound_ctl_pkg::TONE_PATTERN, 16'h01F4, reps[i]);
        repeat (80 * plays[i] - 5) @(posedge mclk);
        chk("tone", 32'h1, tone_active);
        repeat (15) @(posedge mclk);
        chk("tone", 32'h0, tone_active);
      end
    end
    tone(sound_ctl_pkg::TONE_PATTERN, 16'h01F4, 8'hFF);
    repeat (400) @(posedge mclk);
    chk("tone", 32'h1, tone_active);
    tone(sound_ctl_pkg::TONE_STOP, 16'h0000, 8'h00);
    repeat (3) @(posedge mclk);
    chk("tone", 32'h0, tone_active);
    fin("pattern tone");
    // Stalled interpreter: sixteen entries fill the queue, then it drains
    engine_ready <= 1'b0;
    m = '0;
    m.kind = sound_ctl_pkg::MSG_OUT_EN;
    m.cmd = sound_ctl_pkg::AMP_OFF;
    @(posedge mclk);
    msg <= m;
    msg_valid <= 1'b1;
    repeat (16) @(posedge mclk);
    msg_valid <= 1'b0;
    @(posedge mclk);
    chk("full", 32'h0, msg_ready);
    chk("amp", 32'h1, amp_enable_out);
    engine_ready <= 1'b1;
    repeat (24) @(posedge mclk);
    chk("ready", 32'h1, msg_ready);
    chk("amp", 32'h0, amp_enable_out);
    fin("message queue");
    test_done();
  end
endmodule
